// ---- jtlm_defines.vh ----
// Contract
// - quad and dual variants drive eight lanes 0..7; single variant drives four, 0..3.
// - only the lowest lanes of the mode are used; higher lanes power down automatically.
// - in 64B/66B modes multiframe length is derived as 8*32*E/F, not programmed.
// - every tail bit of every frame is sent as zero.
// - each sample goes into its lane frame msb first, lsb last.
// - mode 0: five 12-bit samples plus four tail bits; lane pairs carry even/odd.
// - mode 1: lane 0 A0,A1[11:8]; lane 1 A1[7:0],B0[11:4] or 0x00 single.
// - mode 1: lane 2 B0[3:0],B1; lanes 3..5 repeat for channels C and D.
// - mode 1 frames two octets, two samples per channel; K 16..256 step 16.
`ifndef JTLM_DEFINES_VH
`define JTLM_DEFINES_VH

// ------------------------------------------------------------------
// link modes and frame shapes
// ------------------------------------------------------------------
`define JTLM_MODE_W          4
`define JTLM_MODE_0          4'h0
`define JTLM_MODE_1          4'h1
`define JTLM_SAMPLE_W        12
`define JTLM_SAMPLES_PER_CH  10
`define JTLM_CH_BUS_W        120
`define JTLM_FRAME_W         64
`define JTLM_MODE0_BITS      7'h40
`define JTLM_MODE1_BITS      7'h10
`define JTLM_TAIL_W          4
`define JTLM_MAX_LANES       8
`define JTLM_SINGLE_LANES    4

// ------------------------------------------------------------------
// multiframe length limits
// ------------------------------------------------------------------
`define JTLM_K_W             10
`define JTLM_K_MAX           10'h100
`define JTLM_K_STEP_MODE0    10'h004
`define JTLM_K_STEP_MODE1    10'h010
`define JTLM_K_STEP_OTHER    10'h020
`define JTLM_K_STEP_MODE11   10'h004
`define JTLM_K_FACTOR        10'h100

`endif

// ---- jtlm_lane_shifter.v ----
`timescale 1ns/1ps
`include "jtlm_defines.vh"

module jtlm_lane_shifter #(
   parameter FRAME_W = `JTLM_FRAME_W
) (
   input  wire               ref_clk,
   input  wire               arst_n,
   input  wire               load,
   input  wire               lane_on,
   input  wire [FRAME_W-1:0] frame,
   output reg                serial_bit
);

   reg [FRAME_W-1:0] shreg;

   // ----------------------------------------------------------------
   // msb-first shifter; a powered-down lane holds zero
   // ----------------------------------------------------------------
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         shreg      <= {FRAME_W{1'b0}};
         serial_bit <= 1'b0;
      end else if (!lane_on) begin
         shreg      <= {FRAME_W{1'b0}};
         serial_bit <= 1'b0;
      end else if (load) begin
         serial_bit <= frame[FRAME_W-1];
         shreg      <= {frame[FRAME_W-2:0], 1'b0};
      end else begin
         // zeros fill in behind the frame, so an idle lane sends zeros
         serial_bit <= shreg[FRAME_W-1];
         shreg      <= {shreg[FRAME_W-2:0], 1'b0};
      end
   end

endmodule // jtlm_lane_shifter

// ---- jtlm_lane_mapper.v ----
`timescale 1ns/1ps
`include "jtlm_defines.vh"

module jtlm_lane_mapper #(
   parameter CHANNELS = 4
) (
   input  wire                        ref_clk,
   input  wire                        arst_n,
   input  wire [`JTLM_MODE_W-1:0]     link_mode_select,
   input  wire [`JTLM_K_W-1:0]        k_request,
   input  wire                        sample_valid,
   input  wire [`JTLM_CH_BUS_W-1:0]   sample_a,
   input  wire [`JTLM_CH_BUS_W-1:0]   sample_b,
   input  wire [`JTLM_CH_BUS_W-1:0]   sample_c,
   input  wire [`JTLM_CH_BUS_W-1:0]   sample_d,
   output reg                         frame_ready,
   output reg                         frame_start,
   output reg  [`JTLM_MAX_LANES-1:0]  lane_active,
   output reg                         mode_unsupported,
   output reg  [`JTLM_K_W-1:0]        multiframe_length,
   output wire                        serial_lane_0,
   output wire                        serial_lane_1,
   output wire                        serial_lane_2,
   output wire                        serial_lane_3,
   output wire                        serial_lane_4,
   output wire                        serial_lane_5,
   output wire                        serial_lane_6,
   output wire                        serial_lane_7
);

   // single variant has half the drivers
   localparam NUM_LANES = (CHANNELS == 1) ? `JTLM_SINGLE_LANES : `JTLM_MAX_LANES;

   // ----------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------
   function [`JTLM_SAMPLE_W-1:0] pick;
      input [`JTLM_CH_BUS_W-1:0] s;
      input integer              n;
      begin
         pick = s[n*`JTLM_SAMPLE_W +: `JTLM_SAMPLE_W];
      end
   endfunction

   // mode 0: samples par, par+2, .. par+8, then four zero tail bits
   function [`JTLM_FRAME_W-1:0] mode0_frame;
      input [`JTLM_CH_BUS_W-1:0] s;
      input integer              par;
      integer k;
      begin
         mode0_frame = {`JTLM_FRAME_W{1'b0}};
         for (k = 0; k < 5; k = k + 1) begin
            // earliest sample sits in the leading slot
            mode0_frame[`JTLM_FRAME_W-1-k*`JTLM_SAMPLE_W -: `JTLM_SAMPLE_W] =
               pick(s, 2*k + par);
         end
      end
   endfunction

   // mode 1: three lanes per channel pair, two octets each
   function [`JTLM_FRAME_W-1:0] mode1_frame;
      input [`JTLM_CH_BUS_W-1:0] x;
      input [`JTLM_CH_BUS_W-1:0] y;
      input                      y_ok;
      input integer              pos;
      reg   [11:0]               x0, x1, y0, y1;
      reg   [15:0]               w;
      begin
         x0 = pick(x, 0);
         x1 = pick(x, 1);
         y0 = pick(y, 0);
         y1 = pick(y, 1);
         case (pos)
            0:       w = {x0, x1[11:8]};
            1:       w = {x1[7:0], (y_ok ? y0[11:4] : 8'h00)};
            2:       w = {y0[3:0], y1};
            default: w = 16'h0000;
         endcase
         mode1_frame = {w, 48'h000000000000};
      end
   endfunction

   // lanes used by a mode; everything above is powered down
   function [3:0] lanes_for;
      input [`JTLM_MODE_W-1:0] m;
      begin
         case (m)
            `JTLM_MODE_0: lanes_for = (CHANNELS == 1) ? 4'h2 : ((CHANNELS == 2) ? 4'h4 : 4'h8);
            `JTLM_MODE_1: lanes_for = (CHANNELS == 1) ? 4'h2 : ((CHANNELS == 2) ? 4'h3 : 4'h6);
            default:      lanes_for = 4'h0;
         endcase
      end
   endfunction

   // quantise a requested length to the mode's step, clamped
   function [`JTLM_K_W-1:0] quant;
      input [`JTLM_K_W-1:0] req;
      input [`JTLM_K_W-1:0] step;
      reg   [`JTLM_K_W-1:0] q;
      begin
         q = req - (req % step);
         if (q < step)
            quant = step;
         else if (q > `JTLM_K_MAX)
            quant = `JTLM_K_MAX;
         else
            quant = q;
      end
   endfunction

   // 64B/66B modes get K = 8*32*E/F; others take the programmed value quantised to the mode's step
   function [`JTLM_K_W-1:0] k_for;
      input [`JTLM_MODE_W-1:0] m;
      input [`JTLM_K_W-1:0]    req;
      begin
         case (m)
            4'h0:    k_for = quant(req, `JTLM_K_STEP_MODE0);
            4'h1:    k_for = quant(req, `JTLM_K_STEP_MODE1);
            4'h4:    k_for = (`JTLM_K_FACTOR * 10'h003) / 10'h002;
            4'h5:    k_for = `JTLM_K_FACTOR / 10'h002;
            4'h6:    k_for = (`JTLM_K_FACTOR * 10'h003) / 10'h002;
            4'h7:    k_for = `JTLM_K_FACTOR;
            4'h8:    k_for = `JTLM_K_FACTOR;
            4'he:    k_for = `JTLM_K_FACTOR;
            4'hf:    k_for = (`JTLM_K_FACTOR * 10'h002) / 10'h003;
            4'hb:    k_for = quant(req, `JTLM_K_STEP_MODE11);
            default: k_for = quant(req, `JTLM_K_STEP_OTHER);
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // frame acceptance and bit counting
   // ----------------------------------------------------------------
   reg  [6:0]                  bit_left;
   wire                        accept;
   wire [`JTLM_MODE_W-1:0]     mode_now;
   wire [3:0]                  n_lanes;
   wire [6:0]                  frame_bits;

   assign mode_now   = link_mode_select;
   assign n_lanes    = lanes_for(mode_now);
   assign frame_bits = (mode_now == `JTLM_MODE_0) ? `JTLM_MODE0_BITS : `JTLM_MODE1_BITS;
   // unsupported modes are never accepted, so the lanes stay quiet
   assign accept     = sample_valid & frame_ready & (n_lanes != 4'h0);

   // ready returns on the edge that shows the last bit: frames run back to back
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         bit_left    <= 7'h00;
         frame_ready <= 1'b1;
         frame_start <= 1'b0;
      end else begin
         frame_start <= accept;
         if (accept) begin
            bit_left    <= frame_bits - 7'h01;
            frame_ready <= 1'b0;
         end else if (bit_left != 7'h00) begin
            bit_left    <= bit_left - 7'h01;
            frame_ready <= (bit_left == 7'h01);
         end
      end
   end

   // ----------------------------------------------------------------
   // lane power and status, follow the mode without any command
   // ----------------------------------------------------------------
   reg [`JTLM_MAX_LANES-1:0] next_lane_active;
   integer                   li;

   always @* begin
      next_lane_active = {`JTLM_MAX_LANES{1'b0}};
      for (li = 0; li < `JTLM_MAX_LANES; li = li + 1) begin
         // lowest lanes only, and never past the variant's drivers
         if ((li < n_lanes) && (li < NUM_LANES))
            next_lane_active[li] = 1'b1;
      end
   end

   // lane power follows a mode change between frames only; flag and length follow it at once
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         lane_active       <= {`JTLM_MAX_LANES{1'b0}};
         mode_unsupported  <= 1'b0;
         multiframe_length <= {`JTLM_K_W{1'b0}};
      end else begin
         if (frame_ready)
            lane_active <= next_lane_active;
         mode_unsupported  <= (n_lanes == 4'h0);
         multiframe_length <= k_for(mode_now, k_request);
      end
   end

   // ----------------------------------------------------------------
   // frame building and lane shifters
   // ----------------------------------------------------------------
   reg  [`JTLM_FRAME_W-1:0]    lane_frame [0:`JTLM_MAX_LANES-1];
   wire [`JTLM_MAX_LANES-1:0]  lane_bits;
   wire                        ch_b_ok;
   integer                     fi;

   assign ch_b_ok = (CHANNELS != 1);

   always @* begin
      for (fi = 0; fi < `JTLM_MAX_LANES; fi = fi + 1) begin
         if (mode_now == `JTLM_MODE_0) begin
            case (fi / 2)
               0:       lane_frame[fi] = mode0_frame(sample_a, fi % 2);
               1:       lane_frame[fi] = mode0_frame(sample_b, fi % 2);
               2:       lane_frame[fi] = mode0_frame(sample_c, fi % 2);
               default: lane_frame[fi] = mode0_frame(sample_d, fi % 2);
            endcase
         end else if (fi < 3) begin
            lane_frame[fi] = mode1_frame(sample_a, sample_b, ch_b_ok, fi);
         end else if (fi < 6) begin
            lane_frame[fi] = mode1_frame(sample_c, sample_d, 1'b1, fi - 3);
         end else begin
            lane_frame[fi] = {`JTLM_FRAME_W{1'b0}};
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < `JTLM_MAX_LANES; g = g + 1) begin : g_lane
         jtlm_lane_shifter #(
            .FRAME_W (`JTLM_FRAME_W)
         ) u_shift (
            .ref_clk    (ref_clk),
            .arst_n     (arst_n),
            .load       (accept),
            .lane_on    (accept ? next_lane_active[g] : lane_active[g]),
            .frame      (lane_frame[g]),
            .serial_bit (lane_bits[g])
         );
      end
   endgenerate

   assign serial_lane_0 = lane_bits[0];
   assign serial_lane_1 = lane_bits[1];
   assign serial_lane_2 = lane_bits[2];
   assign serial_lane_3 = lane_bits[3];
   assign serial_lane_4 = lane_bits[4];
   assign serial_lane_5 = lane_bits[5];
   assign serial_lane_6 = lane_bits[6];
   assign serial_lane_7 = lane_bits[7];

endmodule // jtlm_lane_mapper

// ---- jtlm_lane_mapper_checker.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// port checker for the lane mapper
// ----------------------------------------
module jtlm_lane_mapper_checker (
   input logic         ref_clk,
   input logic         arst_n,
   input logic [3:0]   link_mode_select,
   input logic         sample_valid,
   input logic [119:0] sample_a,
   input logic         frame_ready,
   input logic         frame_start,
   input logic [7:0]   lane_active,
   input logic         mode_unsupported,
   input logic [9:0]   multiframe_length,
   input logic         serial_lane_0,
   input logic         serial_lane_1,
   input logic         serial_lane_7
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   // accept edges per mode
   wire acc0 = sample_valid && frame_ready && link_mode_select == 4'h0;
   wire acc1 = sample_valid && frame_ready && link_mode_select == 4'h1;
   property p_start; (acc0 || acc1) |=> frame_start; endproperty
   a_start: assert property (p_start) else $error("no frame start");
   property p_gap0; acc0 |-> ##63 !frame_ready ##1 frame_ready; endproperty
   a_gap0: assert property (p_gap0) else $error("mode 0 frame length");
   property p_gap1;
      acc1 |=> (!frame_ready)[*8] ##1 (!frame_ready)[*7] ##1 frame_ready;
   endproperty
   a_gap1: assert property (p_gap1) else $error("mode 1 frame length");
   property p_lanes0; acc0 |=> lane_active == 8'hff; endproperty
   a_lanes0: assert property (p_lanes0) else $error("mode 0 lane set");
   property p_lanes1; acc1 |=> lane_active == 8'h3f; endproperty
   a_lanes1: assert property (p_lanes1) else $error("mode 1 lane set");
   property p_off; !lane_active[7] |-> !serial_lane_7; endproperty
   a_off: assert property (p_off) else $error("idle lane toggles");
   property p_tail; acc0 |-> ##61 (!serial_lane_0 && !serial_lane_7)[*4]; endproperty
   a_tail: assert property (p_tail) else $error("tail bits set");
   property p_msb;
      acc1 |=> serial_lane_0 == $past(sample_a[11]) && serial_lane_1 == $past(sample_a[19]);
   endproperty
   a_msb: assert property (p_msb) else $error("first bit not msb");
   property p_unsup; 1'b1 |=> mode_unsupported == ($past(link_mode_select) > 4'h1); endproperty
   a_unsup: assert property (p_unsup) else $error("unsupported flag");
   property p_noacc; sample_valid && link_mode_select > 4'h1 |=> !frame_start; endproperty
   a_noacc: assert property (p_noacc) else $error("frame in dead mode");
   property p_k64; link_mode_select == 4'h5 |=> multiframe_length == 10'h080; endproperty
   a_k64: assert property (p_k64) else $error("derived length");
   property p_k1; link_mode_select == 4'h1 |=> multiframe_length[3:0] == 4'h0; endproperty
   a_k1: assert property (p_k1) else $error("mode 1 length step");
endmodule // jtlm_lane_mapper_checker

// ---- jtlm_rx_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// receiver side: collects one frame per lane
// ----------------------------------------
module jtlm_rx_model (
   input  logic         ref_clk,
   input  logic         arst_n,
   input  logic         frame_start,
   input  logic         mode_one,
   input  logic [7:0]   lanes,
   output logic         got,
   output logic [511:0] frame
);
   logic [63:0] sh [8];
   int          cnt = 0;
   int          nb = 64;
   // lanes kept apart so the bench can regroup the sample streams
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt = 0;
         got <= 1'b0;
      end else begin
         got <= 1'b0;
         if (frame_start) begin
            cnt = 0;
            nb = mode_one ? 16 : 64;
            for (int i = 0; i < 8; i++) sh[i] = '0;
         end
         // length fixed at the first bit, msb arrives first
         if (frame_start || cnt > 0) begin
            for (int i = 0; i < 8; i++) sh[i] = {sh[i][62:0], lanes[i]};
            cnt++;
            if (cnt == nb) begin
               cnt = 0;
               got <= 1'b1;
               for (int i = 0; i < 8; i++) frame[64*i +: 64] <= sh[i];
            end
         end
      end
   end
endmodule // jtlm_rx_model

// ---- jtlm_lane_mapper_tb_top.sv ----
`timescale 1ns/1ps
module jtlm_lane_mapper_tb_top;
   logic         ref_clk = 0, arst_n = 0, sample_valid = 0;
   logic [3:0]   link_mode_select = 4'h0;
   logic [9:0]   k_request = 10'h0ff;
   logic [119:0] sa = '0, sb = '0, sc = '0, sd = '0;
   wire          frame_ready, frame_start, mode_unsupported, got;
   wire  [7:0]   lane_active, lanes;
   wire  [9:0]   multiframe_length;
   wire  [511:0] rx_frame;
   logic [511:0] expq [$];
   int           errors = 0, checked = 0;
   // mode, request, expected length
   logic [23:0]  st [9] = '{{4'h0, 10'h0ff, 10'h0fc}, {4'h1, 10'h0ff, 10'h0f0},
      {4'h1, 10'h3ff, 10'h100}, {4'h1, 10'h005, 10'h010}, {4'h5, 10'h0ff, 10'h080},
      {4'h2, 10'h0ff, 10'h0e0}, {4'h4, 10'h0ff, 10'h180}, {4'hf, 10'h0ff, 10'h0aa},
      {4'hb, 10'h0ff, 10'h0fc}};
   jtlm_lane_mapper #(.CHANNELS(4)) DUT (.ref_clk(ref_clk), .arst_n(arst_n),
      .link_mode_select(link_mode_select), .k_request(k_request), .sample_valid(sample_valid),
      .sample_a(sa), .sample_b(sb), .sample_c(sc), .sample_d(sd), .frame_ready(frame_ready),
      .frame_start(frame_start), .lane_active(lane_active), .mode_unsupported(mode_unsupported),
      .multiframe_length(multiframe_length), .serial_lane_0(lanes[0]), .serial_lane_1(lanes[1]),
      .serial_lane_2(lanes[2]), .serial_lane_3(lanes[3]), .serial_lane_4(lanes[4]),
      .serial_lane_5(lanes[5]), .serial_lane_6(lanes[6]), .serial_lane_7(lanes[7]));
   jtlm_rx_model u_rx (.ref_clk(ref_clk), .arst_n(arst_n), .frame_start(frame_start),
      .mode_one(link_mode_select == 4'h1), .lanes(lanes), .got(got), .frame(rx_frame));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   initial forever #25 ref_clk = ~ref_clk;
   task automatic check(input string what, input logic [511:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic results;
      $display("checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   function automatic logic [119:0] rnd();
      return 120'({$urandom, $urandom, $urandom, $urandom});
   endfunction
   // expected lane frames; unused lanes stay zero
   function automatic logic [511:0] build(logic m1, logic [119:0] a, b, c, d);
      logic [119:0] ch [4];
      logic [511:0] f;
      ch = '{a, b, c, d};
      f = '0;
      if (!m1) begin
         for (int i = 0; i < 8; i++)
            for (int j = 0; j < 5; j++)
               f[64*i+63-12*j -: 12] = ch[i/2][12*(2*j+i%2) +: 12];
      end else begin
         for (int p = 0; p < 2; p++) begin
            f[192*p +: 16] = {ch[2*p][11:0], ch[2*p][23:20]};
            f[192*p+64 +: 16] = {ch[2*p][19:12], ch[2*p+1][11:4]};
            f[192*p+128 +: 16] = {ch[2*p+1][3:0], ch[2*p+1][23:12]};
         end
      end
      return f;
   endfunction
   // offer n frames back to back, noting each accepted one
   task automatic send(input logic [3:0] m, input int n);
      for (int k = 0; k < n; k++) begin
         link_mode_select = m;
         k_request = 10'($urandom);
         sa = rnd(); sb = rnd(); sc = rnd(); sd = rnd();
         sample_valid = 1;
         for (int t = 0; t < 100 && frame_ready !== 1'b1; t++) @(negedge ref_clk);
         expq.push_back(build(m == 4'h1, sa, sb, sc, sd));
         @(negedge ref_clk);
      end
      sample_valid = 0;
      for (int t = 0; t < 100 && frame_ready !== 1'b1; t++) @(negedge ref_clk);
      repeat (2) @(negedge ref_clk);
   endtask
   // receiver frames against the oldest note
   always @(negedge ref_clk) if (got === 1'b1) begin
      if (expq.size() == 0) check("spare frame", got, 1'b0);
      else check("lanes", rx_frame, expq.pop_front());
   end
   initial begin
      #400000;
      errors++;
      results();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(92572));
      repeat (12) @(negedge ref_clk);
      arst_n = 1;
      send(4'h0, 3);
      send(4'h1, 4);
      foreach (st[i]) begin
         {link_mode_select, k_request} = st[i][23:10];
         repeat (2) @(negedge ref_clk);
         check("length", {mode_unsupported, multiframe_length},
            {st[i][23:20] > 4'h1, st[i][9:0]});
      end
      // offers in a dead mode must all be ignored
      sample_valid = 1;
      repeat (20) @(negedge ref_clk);
      sample_valid = 0;
      // reset in mid frame drops it and quiets the lanes
      link_mode_select = 4'h0;
      sample_valid = 1;
      @(negedge ref_clk);
      sample_valid = 0;
      repeat (10) @(negedge ref_clk);
      arst_n = 0;
      @(negedge ref_clk);
      expq.delete();
      check("reset", {frame_ready, frame_start, lane_active, lanes}, {2'b10, 16'h0000});
      arst_n = 1;
      send(4'h1, 2);
      send(4'h0, 2);
      check("left", expq.size(), 0);
      results();
   end
endmodule // jtlm_lane_mapper_tb_top
bind jtlm_lane_mapper jtlm_lane_mapper_checker u_chk (.ref_clk(ref_clk), .arst_n(arst_n),
   .link_mode_select(link_mode_select), .sample_valid(sample_valid), .sample_a(sample_a),
   .frame_ready(frame_ready), .frame_start(frame_start), .lane_active(lane_active),
   .mode_unsupported(mode_unsupported), .multiframe_length(multiframe_length),
   .serial_lane_0(serial_lane_0), .serial_lane_1(serial_lane_1), .serial_lane_7(serial_lane_7));
